// ==== include/clsst_pkg.sv ====
// package: offsets, fields, reset values and timing for the lock/strap register bank
package clsst_pkg;
  // register offsets (byte addresses on the wishbone side)
  localparam logic [7:0] OFS_LOCK_ARB_FLASH  = 8'h3b;
  localparam logic [7:0] OFS_STRAP_STATUS    = 8'h3c;
  localparam logic [7:0] OFS_MISC_CFG        = 8'h30;
  localparam logic [7:0] OFS_LOCK_LO         = 8'h20;
  localparam logic [7:0] OFS_LOCK_HI         = 8'h3f;
  // field positions in the lock/arbitration/flash register
  localparam int LOCK_BIT    = 7;
  localparam int OWN_HI      = 6;
  localparam int OWN_LO      = 4;
  localparam int FLASH_HI    = 3;
  localparam int FLASH_LO    = 0;
  // field positions in the strap status register
  localparam int DETECT_BIT  = 7;
  localparam int IDENT_HI    = 6;
  localparam int IDENT_LO    = 4;
  // reset values
  localparam logic [2:0] OWN_RESET   = 3'h4;
  localparam logic [2:0] OWN_DISABLE = 3'h4;
  localparam logic [3:0] FLASH_RESET = 4'h0;
  localparam logic [7:0] MISC_RESET  = 8'h00;
  // ownership periods
  localparam int OWN_STEP_NS = 1000;
  localparam int CLK_NS      = 20;
  localparam int OWN_STEP_CYC = OWN_STEP_NS / CLK_NS;
  // 64KB region numbers (address bits 19:16) per flash protect bit
  localparam logic [3:0] REGION_BIT3 = 4'hf;
  localparam logic [3:0] REGION_BIT2 = 4'he;
  localparam logic [3:0] REGION_BIT1 = 4'hc;
  localparam logic [3:0] REGION_BIT0 = 4'hd;
  // decoded cache module configuration
  typedef enum logic [1:0] {
    CLSST_SZ_1M   = 2'h0,
    CLSST_SZ_512K = 2'h1,
    CLSST_SZ_256K = 2'h2,
    CLSST_SZ_128K = 2'h3
  } clsst_size_t;
  typedef struct packed {
    logic        present;
    logic        write_through;
    clsst_size_t size;
  } clsst_cache_cfg_t;
endpackage

// ==== logic/clsst_regs.sv ====
// lock/arbitration/flash-protect and strap status register bank
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
module clsst_regs #(
  parameter int OWN_STEP_CYCLES = clsst_pkg::OWN_STEP_CYC
) (
  input  wire logic        clk,                  // system clock, 50 MHz
  input  wire logic        srst,                 // synchronous reset, active high
  input  wire logic        wb_cyc_i,             // wishbone cycle
  input  wire logic        wb_stb_i,             // wishbone strobe
  input  wire logic        wb_we_i,              // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,             // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,             // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,             // wishbone write data
  output logic      [31:0] wb_dat_o,             // wishbone read data
  output logic             wb_ack_o,             // wishbone acknowledge
  input  wire logic        refresh_n,            // refresh strobe pin, low active
  input  wire logic        other_master_req,     // bus request from a non-processor master
  output logic             other_master_gnt,     // grant to non-processor master
  output logic             own_timer_busy,       // guaranteed processor period running
  input  wire logic        rom_cycle,            // cycle decodes to rom space
  input  wire logic        rom_cycle_write,      // that cycle is a write
  input  wire logic [19:16] rom_cycle_addr,      // region bits of the cycle address
  output logic             boot_rom_select_n,    // rom chip select, low active
  input  wire logic        module_detect_tag_line, // detect/tag pin
  input  wire logic [2:0]  module_ident_lines,   // identification pins, bit2..bit0
  output clsst_pkg::clsst_cache_cfg_t cache_cfg, // decoded strap configuration
  output logic      [4:2]  cache_tag_hi          // tag bits 4:2 when no module fitted
);

  initial begin
    if (OWN_STEP_CYCLES < 1 || OWN_STEP_CYCLES > 4096) begin
      $error("OWN_STEP_CYCLES out of range");
    end
  end

  // pin synchronisers
  logic [1:0] refresh_sync_reg;
  logic [1:0] detect_sync_reg;
  logic [2:0] ident_s1_reg;
  logic [2:0] ident_s2_reg;
  always_ff @(posedge clk) begin
    refresh_sync_reg <= {refresh_sync_reg[0], refresh_n};
    detect_sync_reg  <= {detect_sync_reg[0], module_detect_tag_line};
    ident_s1_reg     <= module_ident_lines;
    ident_s2_reg     <= ident_s1_reg;
  end
  wire refresh_active = ~refresh_sync_reg[1];

  // strap capture: armed by reset, taken on the first edge after release
  logic       strap_pending_reg;
  logic       detect_strap_reg;
  logic [2:0] ident_strap_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_pending_reg <= 1'b1;
    end else begin
      strap_pending_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (strap_pending_reg) begin
      detect_strap_reg <= detect_sync_reg[1];
      ident_strap_reg  <= ident_s2_reg;
    end
  end

  // wishbone decode
  logic       ack_reg;
  logic [7:0] ctl_reg;
  logic [7:0] misc_reg;
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  // writes land on the edge where the master samples ack, address and data still held
  wire        bus_done  = wb_cyc_i & wb_stb_i & ack_reg;
  wire        wr_lane0  = bus_done & wb_we_i & wb_sel_i[0];
  wire        in_locked = (wb_adr_i >= clsst_pkg::OFS_LOCK_LO) && (wb_adr_i <= clsst_pkg::OFS_LOCK_HI);
  wire        locked    = ctl_reg[clsst_pkg::LOCK_BIT];
  wire        wr_ok     = wr_lane0 & ~(locked & in_locked);
  wire        wr_ctl    = wr_ok & (wb_adr_i == clsst_pkg::OFS_LOCK_ARB_FLASH);
  wire        wr_misc   = wr_ok & (wb_adr_i == clsst_pkg::OFS_MISC_CFG);
  wire [7:0]  wdat      = wb_dat_i[7:0];

  wire [7:0] ctl_next = {
    locked | wdat[clsst_pkg::LOCK_BIT],
    wdat[clsst_pkg::OWN_HI:clsst_pkg::OWN_LO],
    ctl_reg[clsst_pkg::FLASH_HI:clsst_pkg::FLASH_LO] | wdat[clsst_pkg::FLASH_HI:clsst_pkg::FLASH_LO]
  };

  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_reg <= {1'b0, clsst_pkg::OWN_RESET, clsst_pkg::FLASH_RESET};
    end else if (wr_ctl) begin
      ctl_reg <= ctl_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      misc_reg <= clsst_pkg::MISC_RESET;
    end else if (wr_misc) begin
      misc_reg <= wdat;
    end
  end

  // strap status register view
  wire [7:0] status_val = {detect_strap_reg, ident_strap_reg, 4'h0};

  wire [7:0] rd_mux = (wb_adr_i == clsst_pkg::OFS_LOCK_ARB_FLASH) ? ctl_reg :
                      (wb_adr_i == clsst_pkg::OFS_STRAP_STATUS)   ? status_val :
                      (wb_adr_i == clsst_pkg::OFS_MISC_CFG)       ? misc_reg : 8'h00;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_req;
      wb_dat_o <= bus_req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_reg;

  // processor ownership timer
  wire [2:0] own_sel      = ctl_reg[clsst_pkg::OWN_HI:clsst_pkg::OWN_LO];
  wire       own_disabled = own_sel[2];
  wire [2:0] own_steps    = own_sel + 3'h1;
  wire [15:0] own_target  = 16'(OWN_STEP_CYCLES) * 16'(own_steps);
  logic [15:0] own_cnt_reg;
  logic        own_run_reg;
  wire         own_done = (own_cnt_reg + 16'h0001) >= own_target;

  always_ff @(posedge clk) begin
    if (srst || refresh_active) begin
      own_cnt_reg <= 16'h0000;
      own_run_reg <= ~srst;
    end else if (own_run_reg) begin
      own_cnt_reg <= own_cnt_reg + 16'h0001;
      own_run_reg <= ~own_done;
    end
  end

  assign own_timer_busy = own_run_reg & ~own_disabled;
  always_ff @(posedge clk) begin
    if (srst) begin
      other_master_gnt <= 1'b0;
    end else begin
      other_master_gnt <= other_master_req & ~own_timer_busy;
    end
  end

  // rom select with per-region write protection
  wire [3:0] flash_prot = ctl_reg[clsst_pkg::FLASH_HI:clsst_pkg::FLASH_LO];
  wire [3:0] region_hit = {rom_cycle_addr == clsst_pkg::REGION_BIT3,
                           rom_cycle_addr == clsst_pkg::REGION_BIT2,
                           rom_cycle_addr == clsst_pkg::REGION_BIT1,
                           rom_cycle_addr == clsst_pkg::REGION_BIT0};
  wire       blocked    = rom_cycle_write & |(region_hit & flash_prot);
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_rom_select_n <= 1'b1;
    end else begin
      boot_rom_select_n <= ~(rom_cycle & ~blocked);
    end
  end

  // cache module decode
  wire present = ~detect_strap_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      cache_cfg    <= '0;
      cache_tag_hi <= 3'h0;
    end else begin
      cache_cfg.present       <= present;
      cache_cfg.write_through <= ident_strap_reg[2];
      cache_cfg.size          <= clsst_pkg::clsst_size_t'(ident_strap_reg[1:0]);
      cache_tag_hi            <= present ? 3'h0 : ident_s2_reg;
    end
  end

endmodule // clsst_regs

// ==== tb/clsst_monitor.sv ====
// checker for bus, grant and rom select timing
`timescale 1ns/100ps
module clsst_monitor (
  input wire logic         clk,               // clock
  input wire logic         srst,              // reset
  input wire logic         wb_cyc_i,          // cycle
  input wire logic         wb_stb_i,          // strobe
  input wire logic         wb_ack_o,          // ack
  input wire logic [31:0]  wb_dat_o,          // read data
  input wire logic         other_master_req,  // request
  input wire logic         other_master_gnt,  // grant
  input wire logic         own_timer_busy,    // busy
  input wire logic         rom_cycle,         // rom cycle
  input wire logic         rom_cycle_write,   // rom write
  input wire logic [19:16] rom_cycle_addr,    // region
  input wire logic         boot_rom_select_n  // rom select
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_latency: assert property (s_take |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_no_spurious_ack: assert property (!wb_stb_i |=> !wb_ack_o) else $error("ack unasked");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  a_gnt_when_busy: assert property (own_timer_busy |=> !other_master_gnt) else $error("grant in period");
  a_gnt_when_free: assert property (other_master_req && !own_timer_busy |=> other_master_gnt)
    else $error("grant withheld");
  a_rom_read_sel: assert property (rom_cycle && !rom_cycle_write |=> !boot_rom_select_n)
    else $error("read not selected");
  a_rom_open_region: assert property (rom_cycle && rom_cycle_addr < 4'hc |=> !boot_rom_select_n)
    else $error("open region blocked");
  a_rom_idle: assert property (!rom_cycle |=> boot_rom_select_n) else $error("select without cycle");
endmodule // clsst_monitor
bind clsst_regs clsst_monitor u_mon (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .other_master_req,
  .other_master_gnt, .own_timer_busy, .rom_cycle, .rom_cycle_write, .rom_cycle_addr, .boot_rom_select_n);

// ==== tb/clsst_far_side.sv ====
// far side: refresh source and competing bus master
`timescale 1ns/100ps
module clsst_far_side (
  input  wire logic clk,        // clock
  input  wire logic refresh_go, // start one refresh
  output logic      refresh_n,  // refresh strobe, low active
  output logic      req         // competing master request
);
  logic [2:0] cnt_reg = 3'h0;
  assign refresh_n = (cnt_reg == 3'h0);
  assign req = 1'b1;
  always_ff @(posedge clk) begin
    cnt_reg <= refresh_go ? 3'h4 : ((cnt_reg != 3'h0) ? cnt_reg - 3'h1 : cnt_reg);
  end
endmodule // clsst_far_side

// ==== tb/tb.sv ====
// self-checking bench for the lock/strap register bank
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, rc = 1'b0, rw = 1'b0, det = 1'b0;
  logic [7:0] adr = 8'h0, x;
  logic [31:0] dat = 32'h0, dat_o, q[$];
  logic ack, rfn, req, gnt, busy, sel_n;
  logic [3:0] ra = 4'h0;
  logic [2:0] idn = 3'h0, tag;
  clsst_pkg::clsst_cache_cfg_t cfg;
  int errors = 0, checks = 0, seed = 32'h183d, n;
  always #10 clk = ~clk;
  clsst_regs #(.OWN_STEP_CYCLES(4)) uut (.clk, .srst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .refresh_n(rfn), .other_master_req(req),
    .other_master_gnt(gnt), .own_timer_busy(busy), .rom_cycle(rc), .rom_cycle_write(rw), .rom_cycle_addr(ra),
    .boot_rom_select_n(sel_n), .module_detect_tag_line(det), .module_ident_lines(idn), .cache_cfg(cfg),
    .cache_tag_hi(tag));
  clsst_far_side far (.clk, .refresh_go(go), .refresh_n(rfn), .req(req));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    n = 0;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
    {cyc, stb} <= 2'b00;
    if (n >= 50) errors++;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    wb(1'b0, a, 8'h0);
  endtask
  task rst(input logic d, input logic [2:0] i);
    {det, idn, srst} <= {d, i, 1'b1};
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task rom(input logic w, input logic [3:0] r, input logic e);
    @(posedge clk);
    {rc, rw, ra} <= {1'b1, w, r};
    @(posedge clk);
    rc <= 1'b0;
    #1 chk(32'(sel_n), 32'(e));
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && !we)
      chk(dat_o, q.pop_front());
  end
  initial begin
    #100000 errors++;
    results;
  end
  initial begin
    for (int c = 0; c < 8; c++) begin
      rst(1'b0, c[2:0]);
      chk(32'(cfg), {28'h0, 1'b1, c[2:0]});
      rd(clsst_pkg::OFS_STRAP_STATUS, {1'b0, c[2:0], 4'h0});
    end
    x = $random(seed);
    rst(1'b1, x[2:0]);
    chk(32'(tag), 32'(x[2:0]));
    rd(8'h3c, {1'b1, x[2:0], 4'h0});
    rd(8'h3b, 8'h40);
    rd(8'h00, 8'h00);
    for (int s = 0; s < 5; s++) begin
      wb(1'b1, 8'h3b, {1'b0, s[2:0], 4'h0});
      @(posedge clk) go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      while (rfn !== 1'b1) @(posedge clk);
      n = 0;
      repeat (40) @(posedge clk) n += busy;
      chk(32'(n >= (s < 4 ? 4 * s + 4 : 0) && n <= (s < 4 ? 4 * s + 7 : 0)), 32'h1);
      chk(32'(gnt), 32'h1);
    end
    wb(1'b1, 8'h3b, 8'h45);
    for (int r = 0; r < 16; r++) begin
      rom(1'b1, r[3:0], r == 13 || r == 14);
      rom(1'b0, r[3:0], 1'b0);
    end
    wb(1'b1, 8'h3b, 8'h0a);
    rd(8'h3b, 8'h0f);
    rom(1'b1, 4'hf, 1'b1);
    rom(1'b1, 4'hc, 1'b1);
    x = $random(seed);
    wb(1'b1, 8'h30, x);
    rd(8'h30, x);
    wb(1'b1, 8'h3b, 8'hcf);
    wb(1'b1, 8'h30, ~x);
    rd(8'h30, x);
    wb(1'b1, 8'h3b, 8'h00);
    rd(8'h3b, 8'hcf);
    rst(1'b1, x[2:0]);
    rd(8'h3b, 8'h40);
    results;
  end
endmodule // tb
